/* design/phy_event_cfg.svh */
`ifndef PHY_EVENT_CFG_SVH
`define PHY_EVENT_CFG_SVH

// Management register indices
`define REG_SRC_FLAGS       5'h1D
`define REG_EN_MASK         5'h1E
`define REG_LINK_STATUS     5'h1F

// Station address answered on the management bus
`define PHY_ADDR_DEFAULT    5'h01

// Source flag bit positions
`define FLAG_ENERGY         3'h7
`define FLAG_NEG_DONE       3'h6
`define FLAG_REMOTE_FAULT   3'h5
`define FLAG_LINK_DOWN      3'h4
`define FLAG_PARTNER_ACK    3'h3
`define FLAG_PAR_FAULT      3'h2
`define FLAG_PAGE_RX        3'h1

// Reset values
`define MASK_RESET          8'h00
`define STATUS_RSV_RESET    7'h02

// Frame layout
`define PREAMBLE_LEN        6'h20
`define OP_READ             2'h2
`define OP_WRITE            2'h1
`define HDR_LAST            5'h0C
`define WDATA_LAST          5'h11
`define RDATA_BITS          5'h10

// Energy timeout
`define CLK_HZ              10000000
`define ENERGY_TIMEOUT_MS   256
`define ENERGY_TIMEOUT_CYC  (`ENERGY_TIMEOUT_MS * (`CLK_HZ / 1000))
`define ENERGY_CNT_W        22

`endif

/* design/phy_event_pkg.sv */
package phy_event_pkg;

  // Management frame sequencer states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_HDR   = 5'h02,
    ST_TA    = 5'h04,
    ST_RDATA = 5'h08,
    ST_WDATA = 5'h10
  } mdio_state_e;

  typedef logic [15:0] mgmt_word_t;
  typedef logic [7:0]  flag_vec_t;

endpackage

/* design/energy_if.sv */
`timescale 1ns/1ps
interface energy_if;
  logic energy_seen;
  logic energy_present;
  logic energy_change;

  modport timer (
    input  energy_seen,
    output energy_present,
    output energy_change
  );

  modport user (
    output energy_seen,
    input  energy_present,
    input  energy_change
  );
endinterface

/* design/energy_detect_timer.sv */
`timescale 1ns/1ps
`include "phy_event_cfg.svh"
module energy_detect_timer
  import phy_event_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `ENERGY_TIMEOUT_CYC
)(
  input wire logic       clk,
  input wire logic       srst,
  energy_if.timer        ei
);

  logic [`ENERGY_CNT_W-1:0] quiet_cnt_q;
  logic                     present_q;
  logic                     change_q;
  logic                     present_d;
  logic                     timeout;

  // Quiet line for the full window drops the indication
  assign timeout   = (quiet_cnt_q == `ENERGY_CNT_W'(TIMEOUT_CYC - 1));
  assign present_d = ei.energy_seen ? 1'b1 : (timeout ? 1'b0 : present_q);

  // Counter holds at the end so a dead line costs no power
  always_ff @(posedge clk)
  begin
    if (srst)
      quiet_cnt_q <= '0;
    else if (ei.energy_seen)
      quiet_cnt_q <= '0;
    else if (!timeout)
      quiet_cnt_q <= quiet_cnt_q + `ENERGY_CNT_W'(1);
  end

  // Presence starts high after reset; both edges report a change
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      present_q <= 1'b1;
      change_q  <= 1'b0;
    end
    else
    begin
      present_q <= present_d;
      change_q  <= present_d ^ present_q;
    end
  end

  assign ei.energy_present = present_q;
  assign ei.energy_change  = change_q;

endmodule

/* design/phy_event_flags_and_status.sv */
// Function
// - Energy change sets flag bit 7
// - Negotiation completion sets flag bit 6
// - Partner remote fault sets flag bit 5
// - Link going down sets flag bit 4
// - Link-down flag reset follows line state
// - Partner acknowledge sets flag bit 3
// - Parallel detection fault sets flag bit 2
// - Page received sets flag bit 1
// - Flag bits 15-8 and 0 read zero
// - Mask bits 7-0 enable sources, reset zero
// - Status bit 12 shows negotiation done
// - Status bits 4-2 give speed and duplex
// - Registers answer five-bit address, default one
// - Energy drops after 256 ms quiet line
`timescale 1ns/1ps
`include "phy_event_cfg.svh"
module phy_event_flags_and_status
  import phy_event_pkg::*;
#(
  parameter int unsigned ENERGY_TIMEOUT_CYC = `ENERGY_TIMEOUT_CYC
)(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  input  wire logic       line_energy_seen,
  input  wire logic       negotiation_done,
  input  wire logic       remote_fault,
  input  wire logic       link_up,
  input  wire logic       partner_ack,
  input  wire logic       parallel_detect_fault,
  input  wire logic       page_received,
  input  wire logic [2:0] resolved_speed_duplex,
  output logic            phy_irq
);

  energy_if e_if ();

  mdio_state_e state_q;
  logic [5:0]  pre_cnt_q;
  logic [4:0]  bit_cnt_q;
  logic [11:0] hdr_q;
  logic [4:0]  regad_q;
  mgmt_word_t  sh_q;
  logic        mdio_out_q;
  logic        mdio_oe_q;
  logic        mdc_q;
  logic        mdc_rise;
  logic [12:0] hdr_w;
  logic        hdr_last;
  logic        hdr_ok;
  logic        rd_go;
  logic        wr_go;
  logic        clr_src;
  mgmt_word_t  wr_word;
  mgmt_word_t  rd_word;
  flag_vec_t   flags_q;
  flag_vec_t   ev;
  logic [7:0]  mask_q;
  logic [6:0]  rsv_q;
  logic        an_q;
  logic        rf_q;
  logic        link_q;
  logic        irq_q;

  assign e_if.energy_seen = line_energy_seen;

  energy_detect_timer #(
    .TIMEOUT_CYC (ENERGY_TIMEOUT_CYC)
  ) u_energy (
    .clk  (clk),
    .srst (srst),
    .ei   (e_if)
  );

  // Management clock is sampled; only its rising edge moves the frame
  always_ff @(posedge clk)
  begin
    if (srst)
      mdc_q <= 1'b1;
    else
      mdc_q <= mdc;
  end

  assign mdc_rise = mdc & ~mdc_q;

  // Header word: start bit, opcode, station address, register index
  assign hdr_w    = {hdr_q, mdio_in};
  assign hdr_last = (state_q == ST_HDR) && (bit_cnt_q == `HDR_LAST);
  assign hdr_ok   = hdr_w[12] && (hdr_w[9:5] == `PHY_ADDR_DEFAULT);
  assign rd_go    = mdc_rise && hdr_last && hdr_ok && (hdr_w[11:10] == `OP_READ);
  assign clr_src  = rd_go && (hdr_w[4:0] == `REG_SRC_FLAGS);
  assign wr_go    = mdc_rise && (state_q == ST_WDATA) && (bit_cnt_q == `WDATA_LAST);
  assign wr_word  = {sh_q[14:0], mdio_in};

  // Frame sequencer; a frame for another station just drops to idle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q    <= ST_IDLE;
      pre_cnt_q  <= '0;
      bit_cnt_q  <= '0;
      hdr_q      <= '0;
      regad_q    <= '0;
      sh_q       <= '0;
      mdio_out_q <= 1'b0;
      mdio_oe_q  <= 1'b0;
    end
    else if (mdc_rise)
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (mdio_in)
          begin
            if (pre_cnt_q != `PREAMBLE_LEN)
              pre_cnt_q <= pre_cnt_q + 6'h01;
          end
          else
          begin
            if (pre_cnt_q == `PREAMBLE_LEN)
            begin
              state_q   <= ST_HDR;
              bit_cnt_q <= '0;
            end
            pre_cnt_q <= '0;
          end
        end
        ST_HDR:
        begin
          hdr_q     <= hdr_w[11:0];
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (hdr_last)
          begin
            regad_q   <= hdr_w[4:0];
            bit_cnt_q <= '0;
            if (hdr_ok && hdr_w[11:10] == `OP_READ)
            begin
              state_q <= ST_TA;
              sh_q    <= rd_word;
            end
            else if (hdr_ok && hdr_w[11:10] == `OP_WRITE)
              state_q <= ST_WDATA;
            else
              state_q <= ST_IDLE;
          end
        end
        ST_TA:
        begin
          // Second turnaround bit is driven low by us
          mdio_oe_q  <= 1'b1;
          mdio_out_q <= 1'b0;
          state_q    <= ST_RDATA;
          bit_cnt_q  <= '0;
        end
        ST_RDATA:
        begin
          if (bit_cnt_q == `RDATA_BITS)
          begin
            mdio_oe_q  <= 1'b0;
            mdio_out_q <= 1'b0;
            state_q    <= ST_IDLE;
          end
          else
          begin
            mdio_out_q <= sh_q[15];
            sh_q       <= {sh_q[14:0], 1'b0};
            bit_cnt_q  <= bit_cnt_q + 5'h01;
          end
        end
        ST_WDATA:
        begin
          // Two turnaround bits then sixteen data bits
          sh_q <= wr_word;
          if (bit_cnt_q == `WDATA_LAST)
            state_q <= ST_IDLE;
          else
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Read word is snapshotted at the end of the header
  always_comb
  begin
    unique case (hdr_w[4:0])
      `REG_SRC_FLAGS:   rd_word = {8'h00, flags_q[7:1], 1'b0};
      `REG_EN_MASK:     rd_word = {8'h00, mask_q};
      `REG_LINK_STATUS: rd_word = {3'h0, an_q, rsv_q, resolved_speed_duplex, 2'h0};
      default:          rd_word = 16'h0000;
    endcase
  end

  // Previous levels for edge events; link captured so reset makes no event
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      an_q   <= 1'b0;
      rf_q   <= 1'b0;
      link_q <= link_up;
    end
    else
    begin
      an_q   <= negotiation_done;
      rf_q   <= remote_fault;
      link_q <= link_up;
    end
  end

  // Event sources
  assign ev[`FLAG_ENERGY]       = e_if.energy_change;
  assign ev[`FLAG_NEG_DONE]     = negotiation_done & ~an_q;
  assign ev[`FLAG_REMOTE_FAULT] = remote_fault & ~rf_q;
  assign ev[`FLAG_LINK_DOWN]    = ~link_up & link_q;
  assign ev[`FLAG_PARTNER_ACK]  = partner_ack;
  assign ev[`FLAG_PAR_FAULT]    = parallel_detect_fault;
  assign ev[`FLAG_PAGE_RX]      = page_received;
  assign ev[0]                  = 1'b0;

  // Sticky flags: set beats the read clear so no event is lost; bit 0 never sets
  for (genvar i = 0; i < 8; i++)
  begin : g_flag
    always_ff @(posedge clk)
    begin
      if (srst)
        flags_q[i] <= (i == 4) ? ~link_up : 1'b0;
      else
        flags_q[i] <= ev[i] | (flags_q[i] & ~clr_src);
    end
  end

  // Writable fields; read-only ones never see wr_go
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mask_q <= `MASK_RESET;
      rsv_q  <= `STATUS_RSV_RESET;
    end
    else if (wr_go)
    begin
      if (regad_q == `REG_EN_MASK)
        mask_q <= wr_word[7:0];
      if (regad_q == `REG_LINK_STATUS)
        rsv_q <= wr_word[11:5];
    end
  end

  // Registered request avoids glitches from the flag update
  always_ff @(posedge clk)
  begin
    if (srst)
      irq_q <= 1'b0;
    else
      irq_q <= |(flags_q & mask_q);
  end

  assign mdio_out = mdio_out_q;
  assign mdio_oe  = mdio_oe_q;
  assign phy_irq  = irq_q;

endmodule

/* dv/phy_event_flags_and_status_asserts.sv */
`timescale 1ns/1ps
module phy_event_flags_and_status_asserts
  import phy_event_pkg::*;
#(
  parameter int unsigned ENERGY_TIMEOUT_CYC = 2560000
)(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       mdc,
  input wire logic       mdio_in,
  input wire logic       mdio_out,
  input wire logic       mdio_oe,
  input wire logic       phy_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Read turnaround and data phase span many mdc periods
  sequence oe_run;
    mdio_oe[*8];
  endsequence
  sequence oe_off;
    !mdio_oe[*8];
  endsequence

  por_quiet_a: assert property ($fell(srst) |-> !mdio_oe && !mdio_out && !phy_irq)
    else $error("outputs not quiet after reset");
  oe_launch_a: assert property (!$past(mdc) || $past(mdc, 2) |-> $stable(mdio_oe))
    else $error("drive enable moved without mdc rise");
  out_launch_a: assert property (!$past(mdc) || $past(mdc, 2) |-> $stable(mdio_out))
    else $error("data out moved without mdc rise");
  ta_zero_a: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround bit not zero");
  oe_hold_a: assert property ($rose(mdio_oe) |-> oe_run)
    else $error("read drive too short");
  oe_gap_a: assert property ($fell(mdio_oe) |-> oe_off)
    else $error("drive resumed without new frame");
  idle_low_a: assert property (!mdio_oe |-> !mdio_out)
    else $error("data out high while released");
  irq_fall_a: assert property ($fell(phy_irq) |-> $past(mdc, 2) && !$past(mdc, 3))
    else $error("irq dropped without management access");
endmodule

bind phy_event_flags_and_status phy_event_flags_and_status_asserts #(.ENERGY_TIMEOUT_CYC(ENERGY_TIMEOUT_CYC))
  chk_u (.clk, .srst, .mdc, .mdio_in, .mdio_out, .mdio_oe, .phy_irq);

/* dv/mgmt_station.sv */
`timescale 1ns/1ps
module mgmt_station (
  input  wire logic clk,
  output logic      mdc,
  output logic      mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  logic drv;
  // Pull-up holds the wire high when we release it
  assign mdio_in = mdio_oe ? mdio_out : drv;
  initial
  begin
    mdc = 1'b0;
    drv = 1'b1;
  end
  // One mdc period of four clk; sample in the middle of the low half
  task automatic bit_io(input logic b, output logic s);
    @(negedge clk);
    mdc = 1'b0;
    drv = b;
    @(negedge clk);
    s = mdio_in;
    @(negedge clk);
    mdc = 1'b1;
    @(negedge clk);
  endtask
  // Sample of bit j shows what the device launched at rise j-1
  task automatic xfer(input logic [4:0] pa, input logic [1:0] op, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [16:0] rd);
    logic [45:0] hdr;
    logic [17:0] tail;
    logic        s;
    hdr = {32'hFFFFFFFF, 2'h1, op, pa, ra};
    tail = (op == 2'h1) ? {2'h2, wd} : 18'h3FFFF;
    for (int i = 45; i >= 0; i--)
      bit_io(hdr[i], s);
    for (int i = 17; i >= 0; i--)
    begin
      bit_io(tail[i], s);
      if (i < 17)
        rd[i] = s;
    end
  endtask
endmodule

/* dv/phy_event_flags_and_status_test.sv */
`timescale 1ns/1ps
module phy_event_flags_and_status_test;
  import phy_event_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        mdc, mdio_in, mdio_out, mdio_oe, phy_irq;
  logic        line_energy_seen = 1'b1, negotiation_done = 1'b0, remote_fault = 1'b0, link_up = 1'b0;
  logic        partner_ack = 1'b0, parallel_detect_fault = 1'b0, page_received = 1'b0;
  logic [2:0]  resolved_speed_duplex = 3'h1;
  logic [2:0]  codes [4] = '{3'h1, 3'h5, 3'h2, 3'h6};
  logic [16:0] got;
  logic [7:0]  m;
  int          b, mismatches = 0, checked = 0;

  // 10 MHz system clock
  always #50 clk = ~clk;

  phy_event_flags_and_status #(.ENERGY_TIMEOUT_CYC(50)) dut_u (.clk, .srst, .mdc, .mdio_in, .mdio_out,
    .mdio_oe, .line_energy_seen, .negotiation_done, .remote_fault, .link_up, .partner_ack,
    .parallel_detect_fault, .page_received, .resolved_speed_duplex, .phy_irq);
  mgmt_station mgr_u (.clk, .mdc, .mdio_in, .mdio_out, .mdio_oe);

  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h got %h", nm, e, g);
    end
  endtask
  // Reads also check the turnaround zero in bit 16
  task automatic rdchk(input string nm, input logic [4:0] ra, input logic [15:0] e);
    mgr_u.xfer(5'h01, 2'h2, ra, 16'h0000, got);
    chk(nm, {1'b0, e}, got);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    mgr_u.xfer(5'h01, 2'h1, ra, d, got);
  endtask
  task automatic rst(input logic l);
    @(negedge clk);
    link_up = l;
    srst = 1'b1;
    repeat (6) @(negedge clk);
    srst = 1'b0;
  endtask
  function automatic logic [15:0] stat(input logic d, input logic [2:0] s);
    return {3'h0, d, 7'h02, s, 2'h0};
  endfunction
  // Energy loss must outlast the shortened quiet timeout of 50
  task automatic fire(input int ev);
    @(negedge clk);
    case (ev)
      1: page_received = 1'b1;
      2: parallel_detect_fault = 1'b1;
      3: partner_ack = 1'b1;
      4: link_up = 1'b0;
      5: remote_fault = 1'b1;
      6: negotiation_done = 1'b1;
      default: line_energy_seen = 1'b0;
    endcase
    repeat (ev == 7 ? 60 : 1) @(negedge clk);
    {page_received, parallel_detect_fault, partner_ack, remote_fault, negotiation_done} = 5'h00;
    link_up = 1'b1;
    line_energy_seen = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (90000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  initial
  begin
    b = $urandom(32'h117D461F);
    rst(1'b0);
    rdchk("flags_rst", 5'h1D, 16'h0010);
    rdchk("mask_rst", 5'h1E, 16'h0000);
    rdchk("status_rst", 5'h1F, stat(1'b0, 3'h1));
    rst(1'b1);
    rdchk("flags_rst_up", 5'h1D, 16'h0000);
    $display("reset test done");
    for (int i = 1; i < 8; i++)
    begin
      fire(i);
      rdchk("flag_set", 5'h1D, 16'h0001 << i);
      rdchk("flag_clr", 5'h1D, 16'h0000);
    end
    // Pulse lands on the clearing edge of a flag read; the set must survive
    fork
      rdchk("race_read", 5'h1D, 16'h0000);
      begin
        repeat (183) @(negedge clk);
        page_received = 1'b1;
        @(negedge clk);
        page_received = 1'b0;
      end
    join
    rdchk("race_kept", 5'h1D, 16'h0002);
    $display("source test done");
    for (int k = 0; k < 6; k++)
    begin
      m = (k == 0) ? 8'hFF : 8'($urandom);
      b = $urandom_range(7, 1);
      wr(5'h1E, {8'h00, m});
      rdchk("mask_rw", 5'h1E, {8'h00, m});
      fire(b);
      chk("irq", {16'h0000, m[b]}, {16'h0000, phy_irq});
      rdchk("flag_hit", 5'h1D, 16'h0001 << b);
      chk("irq_clr", 17'h00000, {16'h0000, phy_irq});
    end
    $display("mask test done");
    wr(5'h1D, 16'hFFFF);
    rdchk("flags_ro", 5'h1D, 16'h0000);
    negotiation_done = 1'b1;
    foreach (codes[j])
    begin
      resolved_speed_duplex = codes[j];
      wr(5'h1F, 16'hF05F);
      rdchk("status", 5'h1F, stat(1'b1, codes[j]));
    end
    rdchk("done_flag", 5'h1D, 16'h0040);
    rdchk("unmapped", 5'h10, 16'h0000);
    mgr_u.xfer(5'h02, 2'h2, 5'h1E, 16'h0000, got);
    chk("other_addr", 17'h1FFFF, got);
    // Opcode 11 is neither read nor write, so the wire must stay released
    mgr_u.xfer(5'h01, 2'h3, 5'h1E, 16'h0000, got);
    chk("bad_op", 17'h1FFFF, got);
    $display("status test done");
    wrap_up();
  end
endmodule
